/* mbs_rtu_frame.v */
// Summary of operation
// - exception function code is request plus 0x80
// - unsupported function code answers exception 01
// - bad data address answers exception 02
// - bad length or crc answers exception 03
// - execution failure answers exception 04
// - value out of range answers exception 05
// - read-only register write answers exception 06
// - running-locked write while running answers 07
// - password-protected register answers exception 08
// - 3.5 character idle marks frame boundaries
// - 1.5 character gap inside frame discards it
// - tick thresholds per bit rate for gaps
// - legal frame: own or broadcast address, at least three bytes
// - illegal frames silent, legal bad frames get exception, except broadcasts faulted by the application
// - reply waits configured delay, never below minimum
// - nonvolatile work may lengthen the reply delay
// - valid frame: function, length and crc correct
// - timeout when valid frames stop, zero disables
// - single write answered by exact request echo
// - uart error in request gives no reply
//
// Purpose: slave-side rtu framing, checking and answering
// Assumes: byte stream from a uart, application decides register faults
// Notes: only echo-type functions (0x41, 0x06, 0x08) are answered normally
`timescale 1ns/1ns
`include "mbs_map.vh"

module mbs_rtu_frame #(
    parameter TICK_CYCLES = `MBS_CLK_HZ / 1000000 * `MBS_TICK_US,
    parameter TICK_W = 17
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // configuration
    input wire [7:0] dev_addr,
    input wire [1:0] baud_sel,
    input wire [7:0] response_delay_setting,
    input wire [15:0] comm_timeout_setting,
    input wire drive_running,
    // receive byte stream from uart
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_err,
    // transmit byte stream to uart
    output reg tx_valid_r,
    output reg [7:0] tx_data_r,
    input wire tx_ready,
    output reg tx_en_r,
    // request to the application
    output reg req_valid_r,
    output reg [7:0] req_fc_r,
    output reg [15:0] req_reg_r,
    output reg [15:0] req_value_r,
    output reg req_bcast_r,
    // application verdict
    input wire app_done,
    input wire app_addr_bad,
    input wire app_read_only,
    input wire app_run_locked,
    input wire app_password,
    input wire app_range_bad,
    input wire app_fault,
    input wire app_nvm_busy,
    // status
    output reg comm_timeout_r,
    output reg frame_drop_r
);

    localparam S_RX = 3'd0;
    localparam S_CHECK = 3'd1;
    localparam S_APP = 3'd2;
    localparam S_DELAY = 3'd3;
    localparam S_SEND = 3'd4;
    localparam SETTLE_TICKS = (`MBS_SETTLE_US + `MBS_TICK_US - 1) / `MBS_TICK_US;

    reg [2:0] state_r;
    reg [TICK_W-1:0] div_r;
    reg tick_r;
    reg [3:0] gap_r;
    reg [3:0] rx_cnt_r;
    reg rx_bad_r;
    reg rx_over_r;
    reg [15:0] rx_crc_r;
    reg [7:0] buf_r [0:7];
    reg [7:0] dly_r;
    reg [15:0] idle_ms_r;
    reg exc_r;
    reg [7:0] exc_code_r;
    reg [3:0] tx_idx_r;
    reg [3:0] tx_len_r;
    reg [15:0] tx_crc_r;
    reg [3:0] gap_thr;
    reg [3:0] abn_thr;
    reg [7:0] min_dly;
    reg [7:0] need_dly;
    reg [7:0] tx_next;
    reg fc_ok;
    wire [15:0] rx_crc_nxt;
    wire [15:0] tx_crc_nxt;
    wire rx_take;
    wire tx_take;
    wire addr_ok;
    wire crc_ok;
    integer k;

    // thresholds per bit rate
    always @* begin
        case (baud_sel)
            `MBS_BAUD_4800: begin
                gap_thr = `MBS_GAP_4800;
                abn_thr = `MBS_ABN_4800;
            end
            `MBS_BAUD_9600: begin
                gap_thr = `MBS_GAP_9600;
                abn_thr = `MBS_ABN_9600;
            end
            `MBS_BAUD_19200: begin
                gap_thr = `MBS_GAP_19200;
                abn_thr = `MBS_ABN_19200;
            end
            default: begin
                gap_thr = `MBS_GAP_FAST;
                abn_thr = `MBS_ABN_FAST;
            end
        endcase
        min_dly = {4'h0, gap_thr} + SETTLE_TICKS[7:0];
        need_dly = (response_delay_setting > min_dly) ? response_delay_setting : min_dly;
        fc_ok = (buf_r[1] == `MBS_FC_WRITE) || (buf_r[1] == `MBS_FC_WRITE_STD) ||
                (buf_r[1] == `MBS_FC_DIAG);
    end

    assign rx_take = rx_valid && (state_r == S_RX);
    assign tx_take = tx_valid_r && tx_ready;
    assign addr_ok = (buf_r[0] == dev_addr) || (buf_r[0] == `MBS_BCAST_ADDR);
    // crc residue over a frame including its own crc is zero
    assign crc_ok = (rx_crc_r == 16'h0000);

    mbs_crc16 u_rx_crc (
        .crc_in(rx_crc_r),
        .data_in(rx_data),
        .crc_out(rx_crc_nxt)
    );

    mbs_crc16 u_tx_crc (
        .crc_in(tx_crc_r),
        .data_in(tx_data_r),
        .crc_out(tx_crc_nxt)
    );

    // outgoing byte for index; echo replays stored bytes untouched
    always @* begin
        tx_next = buf_r[tx_idx_r[2:0]];
        if (exc_r) begin
            case (tx_idx_r)
                4'd0: tx_next = buf_r[0];
                4'd1: tx_next = buf_r[1] | `MBS_EXC_FLAG;
                4'd2: tx_next = exc_code_r;
                4'd3: tx_next = tx_crc_r[7:0];
                default: tx_next = tx_crc_r[15:8];
            endcase
        end
    end

    // 1 ms tick divider
    always @(posedge sys_clk) begin
        if (rst) begin
            div_r <= {TICK_W{1'b0}};
            tick_r <= 1'b0;
        end else if (div_r == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
            div_r <= {TICK_W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // line idle measurement, saturating; own transmit counts as activity
    always @(posedge sys_clk) begin
        if (rst) begin
            gap_r <= 4'h0;
        end else if (rx_valid || tx_take) begin
            gap_r <= 4'h0;
        end else if (tick_r && gap_r != 4'hf) begin
            gap_r <= gap_r + 1'b1;
        end
    end

    // communication timeout
    always @(posedge sys_clk) begin
        if (rst) begin
            idle_ms_r <= 16'h0000;
            comm_timeout_r <= 1'b0;
        end else begin
            if (state_r == S_CHECK && addr_ok && crc_ok && fc_ok && !rx_bad_r &&
                rx_cnt_r == `MBS_ECHO_LEN && !rx_over_r) begin
                idle_ms_r <= 16'h0000;
            end else if (tick_r && idle_ms_r != 16'hffff) begin
                idle_ms_r <= idle_ms_r + 1'b1;
            end
            comm_timeout_r <= (comm_timeout_setting != 16'h0000) &&
                              (idle_ms_r > comm_timeout_setting);
        end
    end

    // main sequence
    always @(posedge sys_clk) begin
        if (rst) begin
            state_r <= S_RX;
            rx_cnt_r <= 4'h0;
            rx_bad_r <= 1'b0;
            rx_over_r <= 1'b0;
            rx_crc_r <= `MBS_CRC_INIT;
            dly_r <= 8'h00;
            exc_r <= 1'b0;
            exc_code_r <= 8'h00;
            tx_idx_r <= 4'h0;
            tx_len_r <= 4'h0;
            tx_crc_r <= `MBS_CRC_INIT;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_en_r <= 1'b0;
            req_valid_r <= 1'b0;
            req_fc_r <= 8'h00;
            req_reg_r <= 16'h0000;
            req_value_r <= 16'h0000;
            req_bcast_r <= 1'b0;
            frame_drop_r <= 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                buf_r[k] <= 8'h00;
            end
        end else begin
            req_valid_r <= 1'b0;
            frame_drop_r <= 1'b0;
            if (tick_r && state_r != S_RX && state_r != S_SEND && dly_r != 8'hff) begin
                dly_r <= dly_r + 1'b1;
            end
            case (state_r)
                S_RX: begin
                    if (rx_take) begin
                        if (rx_cnt_r == 4'h0 && gap_r < gap_thr) begin
                            rx_bad_r <= 1'b1;
                        end
                        if (rx_cnt_r != 4'h0 && gap_r >= abn_thr) begin
                            rx_bad_r <= 1'b1;
                        end
                        if (rx_err) begin
                            rx_bad_r <= 1'b1;
                        end
                        if (rx_cnt_r[3]) begin
                            rx_over_r <= 1'b1;
                        end else begin
                            buf_r[rx_cnt_r[2:0]] <= rx_data;
                            rx_cnt_r <= rx_cnt_r + 1'b1;
                        end
                        rx_crc_r <= rx_crc_nxt;
                    end else if (rx_cnt_r != 4'h0 && gap_r >= gap_thr) begin
                        state_r <= S_CHECK;
                        dly_r <= 8'h00;
                    end
                end
                S_CHECK: begin
                    exc_r <= 1'b1;
                    if (rx_bad_r || rx_cnt_r < `MBS_MIN_LEN || !addr_ok) begin
                        frame_drop_r <= 1'b1;
                        state_r <= S_RX;
                    end else if (!crc_ok) begin
                        exc_code_r <= `MBS_EXC_FRAME;
                        state_r <= S_DELAY;
                    end else if (!fc_ok) begin
                        exc_code_r <= `MBS_EXC_FUNC;
                        state_r <= S_DELAY;
                    end else if (rx_over_r || rx_cnt_r != `MBS_ECHO_LEN) begin
                        exc_code_r <= `MBS_EXC_FRAME;
                        state_r <= S_DELAY;
                    end else begin
                        req_valid_r <= 1'b1;
                        req_fc_r <= buf_r[1];
                        req_reg_r <= {buf_r[2], buf_r[3]};
                        req_value_r <= {buf_r[4], buf_r[5]};
                        req_bcast_r <= (buf_r[0] == `MBS_BCAST_ADDR);
                        state_r <= S_APP;
                    end
                    if (state_r == S_CHECK) begin
                        rx_cnt_r <= rx_cnt_r;
                    end
                end
                S_APP: begin
                    if (app_done) begin
                        exc_r <= 1'b1;
                        state_r <= S_DELAY;
                        if (app_addr_bad) begin
                            exc_code_r <= `MBS_EXC_ADDR;
                        end else if (app_read_only) begin
                            exc_code_r <= `MBS_EXC_RDONLY;
                        end else if (app_run_locked && drive_running) begin
                            exc_code_r <= `MBS_EXC_RUNNING;
                        end else if (app_password) begin
                            exc_code_r <= `MBS_EXC_PASSWD;
                        end else if (app_range_bad) begin
                            exc_code_r <= `MBS_EXC_RANGE;
                        end else if (app_fault) begin
                            exc_code_r <= `MBS_EXC_FAULT;
                        end else begin
                            exc_r <= 1'b0;
                        end
                        // broadcasts reaching the application are executed but never answered
                        if (req_bcast_r) begin
                            state_r <= S_RX;
                        end
                    end
                end
                S_DELAY: begin
                    if (dly_r >= need_dly && !app_nvm_busy) begin
                        state_r <= S_SEND;
                        tx_idx_r <= 4'h0;
                        tx_crc_r <= `MBS_CRC_INIT;
                        tx_len_r <= exc_r ? `MBS_EXC_LEN : `MBS_ECHO_LEN;
                        tx_en_r <= 1'b1;
                    end
                end
                S_SEND: begin
                    if (!tx_valid_r) begin
                        tx_valid_r <= 1'b1;
                        tx_data_r <= tx_next;
                    end else if (tx_take) begin
                        tx_valid_r <= 1'b0;
                        tx_idx_r <= tx_idx_r + 1'b1;
                        // freeze once the crc bytes themselves go out
                        if (tx_idx_r < 4'd3) begin
                            tx_crc_r <= tx_crc_nxt;
                        end
                        if (tx_idx_r + 1'b1 == tx_len_r) begin
                            tx_en_r <= 1'b0;
                            state_r <= S_RX;
                        end
                    end
                end
                default: begin
                    state_r <= S_RX;
                end
            endcase
            if (state_r != S_RX && state_r != S_CHECK) begin
                rx_cnt_r <= 4'h0;
                rx_bad_r <= 1'b0;
                rx_over_r <= 1'b0;
                rx_crc_r <= `MBS_CRC_INIT;
            end
            if (state_r == S_CHECK && (rx_bad_r || rx_cnt_r < `MBS_MIN_LEN || !addr_ok)) begin
                rx_cnt_r <= 4'h0;
                rx_bad_r <= 1'b0;
                rx_over_r <= 1'b0;
                rx_crc_r <= `MBS_CRC_INIT;
            end
        end
    end

endmodule // mbs_rtu_frame

/* mbs_map.vh */
// Purpose: constants for the rtu slave framer
// Assumes: 1 ms timing tick, byte stream from an external uart
// Notes: definitions only
`ifndef MBS_MAP_VH
`define MBS_MAP_VH

// clock and tick
`define MBS_CLK_HZ 100000000
`define MBS_TICK_US 1000
`define MBS_SETTLE_US 1000

// exception answer
`define MBS_EXC_FLAG 8'h80
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_EXC_FRAME 8'h03
`define MBS_EXC_FAULT 8'h04
`define MBS_EXC_RANGE 8'h05
`define MBS_EXC_RDONLY 8'h06
`define MBS_EXC_RUNNING 8'h07
`define MBS_EXC_PASSWD 8'h08

// addresses and function codes
`define MBS_BCAST_ADDR 8'h00
`define MBS_FC_WRITE 8'h41
`define MBS_FC_WRITE_STD 8'h06
`define MBS_FC_DIAG 8'h08

// frame lengths
`define MBS_MIN_LEN 4'd3
`define MBS_ECHO_LEN 4'd8
`define MBS_EXC_LEN 4'd5

// bit rate select
`define MBS_BAUD_4800 2'd0
`define MBS_BAUD_9600 2'd1
`define MBS_BAUD_19200 2'd2

// gap thresholds in ticks
`define MBS_GAP_4800 4'd8
`define MBS_GAP_9600 4'd4
`define MBS_GAP_19200 4'd2
`define MBS_GAP_FAST 4'd1
`define MBS_ABN_4800 4'd4
`define MBS_ABN_9600 4'd2
`define MBS_ABN_19200 4'd1
`define MBS_ABN_FAST 4'd1

// crc
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001

`endif

/* mbs_crc16.v */
// Purpose: one-byte update of the reflected crc16
// Assumes: lsb-first polynomial, caller holds the running value
// Notes: purely combinational, eight shift steps unrolled by a loop
`timescale 1ns/1ns
`include "mbs_map.vh"

module mbs_crc16 (
    // running value
    input wire [15:0] crc_in,
    input wire [7:0] data_in,
    // updated value
    output reg [15:0] crc_out
);

    integer i;

    always @* begin
        crc_out = crc_in ^ {8'h00, data_in};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `MBS_CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule // mbs_crc16

/* mbs_rtu_frame_checker.sv */
// Purpose: concurrent checks on the rtu slave framer ports
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every framer instance
`timescale 1ns/1ns
module mbs_rtu_frame_checker #(
    parameter TICK_CYCLES = 100000
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // configuration
    input wire [1:0] baud_sel,
    input wire [7:0] response_delay_setting,
    input wire [15:0] comm_timeout_setting,
    // byte streams
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_err,
    input wire tx_valid_r,
    input wire [7:0] tx_data_r,
    input wire tx_ready,
    input wire tx_en_r,
    // request and status
    input wire req_valid_r,
    input wire req_bcast_r,
    input wire comm_timeout_r,
    input wire frame_drop_r
);
    logic [19:0] idle_r;
    logic [3:0] rx_idx_r;
    logic [3:0] tx_idx_r;
    logic [7:0] fc_seen_r;
    logic err_seen_r;
    logic bcast_r;
    logic [7:0] gap_ticks;
    logic [7:0] dly_ticks;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    always @* begin
        case (baud_sel)
            2'd0: gap_ticks = 8'd8;
            2'd1: gap_ticks = 8'd4;
            2'd2: gap_ticks = 8'd2;
            default: gap_ticks = 8'd1;
        endcase
        // lower bound only: tick phase blurs the frame end by up to one tick
        dly_ticks = (response_delay_setting > gap_ticks) ? response_delay_setting : gap_ticks + 8'd1;
    end
    always @(posedge sys_clk) begin
        if (rst) begin
            idle_r <= 20'h0;
            rx_idx_r <= 4'h0;
            tx_idx_r <= 4'h0;
            fc_seen_r <= 8'h00;
            err_seen_r <= 1'b0;
            bcast_r <= 1'b0;
        end else begin
            idle_r <= rx_valid ? 20'h0 : idle_r + {19'h0, ~&idle_r};
            if (tx_en_r || frame_drop_r || (req_valid_r && req_bcast_r))
                rx_idx_r <= 4'h0;
            else if (rx_valid && rx_idx_r != 4'hf)
                rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_valid && rx_idx_r == 4'h1)
                fc_seen_r <= rx_data;
            tx_idx_r <= !tx_en_r ? 4'h0 : tx_idx_r + {3'h0, tx_valid_r & tx_ready};
            err_seen_r <= frame_drop_r ? 1'b0 : err_seen_r | (rx_valid & rx_err);
            bcast_r <= rx_valid ? 1'b0 : bcast_r | (req_valid_r & req_bcast_r);
        end
    end
    chk_reply_fc_match:
        assert property (tx_valid_r && tx_ready && tx_idx_r == 4'h1 |-> tx_data_r[6:0] == fc_seen_r[6:0])
        else $error("reply function code differs from request");
    chk_tx_byte_hold:
        assert property (tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
        else $error("offered byte changed before taken");
    chk_tx_in_enable:
        assert property (tx_valid_r |-> tx_en_r) else $error("byte offered without drive enable");
    chk_reply_min_delay:
        assert property ($rose(tx_en_r) |-> idle_r > (dly_ticks - 8'd1) * TICK_CYCLES)
        else $error("reply started too early");
    chk_drop_stays_quiet:
        assert property (frame_drop_r |=> !tx_en_r [*8]) else $error("reply after dropped frame");
    chk_err_no_request:
        assert property (req_valid_r |-> !err_seen_r) else $error("request from errored frame");
    chk_bcast_no_reply:
        assert property ($rose(tx_en_r) |-> !bcast_r) else $error("reply to broadcast");
    chk_drop_or_request:
        assert property (frame_drop_r |-> !req_valid_r) else $error("drop and request together");
    chk_timeout_disabled:
        assert property (comm_timeout_setting == 16'h0 ##1 comm_timeout_setting == 16'h0
            |-> !comm_timeout_r) else $error("timeout while disabled");
    cover property ($rose(tx_en_r));
    cover property (frame_drop_r);
    cover property ($rose(comm_timeout_r));
endmodule // mbs_rtu_frame_checker

bind mbs_rtu_frame mbs_rtu_frame_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .baud_sel(baud_sel),
    .response_delay_setting(response_delay_setting), .comm_timeout_setting(comm_timeout_setting),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .tx_valid_r(tx_valid_r),
    .tx_data_r(tx_data_r), .tx_ready(tx_ready), .tx_en_r(tx_en_r), .req_valid_r(req_valid_r),
    .req_bcast_r(req_bcast_r), .comm_timeout_r(comm_timeout_r), .frame_drop_r(frame_drop_r)
);

/* mbs_master_model.sv */
// Purpose: external master on the byte streams of the framer
// Assumes: inputs driven at the falling edge
// Notes: slow set makes the reply side stall three cycles in four
`timescale 1ns/1ns
module mbs_master_model (
    // clock
    input wire sys_clk,
    // request bytes toward the slave
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_err,
    // reply bytes from the slave
    input wire tx_valid_r,
    input wire [7:0] tx_data_r,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    logic [1:0] ph = 2'h0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h5a;
        rx_err = 1'b0;
        tx_ready = 1'b0;
    end
    always @(negedge sys_clk) begin
        ph <= ph + 2'h1;
        tx_ready <= !slow || ph == 2'h3;
    end
    always @(posedge sys_clk) begin
        if (tx_valid_r && tx_ready)
            got.push_back(tx_data_r);
    end
    // idle before the frame and spacing inside it are the caller's choice
    task automatic send(input logic [7:0] q[$], input int pre, input int sp, input int erri);
        repeat (pre) @(negedge sys_clk);
        foreach (q[i]) begin
            rx_valid = 1'b1;
            rx_data = q[i];
            rx_err = (i == erri);
            @(negedge sys_clk);
            // back-to-back bytes keep the strobe up instead of pulsing it in zero time
            if (sp > 0 || i == q.size() - 1) begin
                rx_valid = 1'b0;
                rx_data = ~q[i];
                rx_err = 1'b0;
            end
            repeat (sp) @(negedge sys_clk);
        end
    endtask
endmodule // mbs_master_model

/* mbs_rtu_frame_tb.sv */
// Purpose: self-checking bench for the rtu slave framer
// Assumes: 10-cycle tick, slave address 0x01
// Notes: table rows cover answer codes, hand tests the silent cases
`timescale 1ns/1ns
`include "mbs_map.vh"
module mbs_rtu_frame_tb;
    typedef logic [7:0] mbs_bq_t[$];
    // function, app flags, running and bad crc, expected code (0 = echo)
    localparam logic [23:0] ROWS [13] = '{
        {8'h41, 6'h00, 2'h0, 8'h00}, {8'h06, 6'h00, 2'h0, 8'h00}, {8'h08, 6'h00, 2'h0, 8'h00},
        {8'h03, 6'h00, 2'h0, 8'h01}, {8'h41, 6'h20, 2'h0, 8'h02}, {8'h41, 6'h30, 2'h0, 8'h02},
        {8'h41, 6'h00, 2'h1, 8'h03}, {8'h41, 6'h01, 2'h0, 8'h04}, {8'h41, 6'h02, 2'h0, 8'h05},
        {8'h41, 6'h10, 2'h0, 8'h06}, {8'h41, 6'h08, 2'h2, 8'h07}, {8'h41, 6'h08, 2'h0, 8'h00},
        {8'h41, 6'h04, 2'h0, 8'h08}
    };
    logic sys_clk, rst, running, nvm, app_done, req_seen, bad;
    logic [1:0] baud_sel;
    logic [5:0] fl;
    logic [7:0] resp_dly, fc, code;
    logic [15:0] tmo;
    wire tx_valid_r, tx_ready, tx_en_r, req_valid_r, req_bcast_r, comm_timeout_r, frame_drop_r;
    wire rx_valid, rx_err;
    wire [7:0] rx_data, tx_data_r, req_fc_r;
    wire [15:0] req_reg_r, req_value_r;
    int checked = 0;
    int mismatches = 0;
    int drops = 0;
    int d0;
    mbs_bq_t f, e, none;
    mbs_rtu_frame #(.TICK_CYCLES(10)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .dev_addr(8'h01), .baud_sel(baud_sel),
        .response_delay_setting(resp_dly), .comm_timeout_setting(tmo), .drive_running(running),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .tx_valid_r(tx_valid_r),
        .tx_data_r(tx_data_r), .tx_ready(tx_ready), .tx_en_r(tx_en_r), .req_valid_r(req_valid_r),
        .req_fc_r(req_fc_r), .req_reg_r(req_reg_r), .req_value_r(req_value_r),
        .req_bcast_r(req_bcast_r),
        .app_done(app_done), .app_addr_bad(fl[5]), .app_read_only(fl[4]), .app_run_locked(fl[3]),
        .app_password(fl[2]), .app_range_bad(fl[1]), .app_fault(fl[0]), .app_nvm_busy(nvm),
        .comm_timeout_r(comm_timeout_r), .frame_drop_r(frame_drop_r)
    );
    mbs_master_model m (
        .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
        .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_ready(tx_ready)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // application answers one cycle after each request
    always @(posedge sys_clk) req_seen <= req_valid_r;
    always @(negedge sys_clk) app_done <= req_seen;
    always @(posedge sys_clk) if (frame_drop_r === 1'b1) drops++;
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = `MBS_CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `MBS_CRC_POLY : c >> 1;
        end
        return c;
    endfunction
    function automatic mbs_bq_t frame(input logic [7:0] q[$], input logic flip);
        logic [15:0] c;
        c = crc(q);
        q.push_back(c[7:0] ^ {7'h0, flip});
        q.push_back(c[15:8]);
        return q;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_reply(input logic [7:0] x[$]);
        int n;
        n = 0;
        while (n < 600 && (x.size() == 0 || m.got.size() < x.size())) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (20) @(negedge sys_clk);
        check(16'(m.got.size()), 16'(x.size()));
        foreach (x[i]) if (i < m.got.size()) check({8'h00, m.got[i]}, {8'h00, x[i]});
        m.got.delete();
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #300_000;
        mismatches++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        {running, nvm, fl} = 8'h0;
        baud_sel = `MBS_BAUD_9600;
        resp_dly = 8'd6;
        tmo = 16'h0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        foreach (ROWS[r]) begin
            {fc, fl, running, bad, code} = ROWS[r];
            m.slow = r[0];
            f = frame('{8'h01, fc, 8'h70, 8'h00, 8'h00, 8'h01}, bad);
            e = (code == 8'h00) ? f : frame('{8'h01, fc | `MBS_EXC_FLAG, code}, 1'b0);
            m.send(f, 60, 2, -1);
            expect_reply(e);
        end
        {running, fl} = 7'h0;
        d0 = drops;
        f = frame('{8'h01, 8'h41, 8'h70, 8'h00, 8'h00, 8'h01}, 1'b0);
        m.send(frame('{8'h05, 8'h41, 8'h70, 8'h00, 8'h00, 8'h01}, 1'b0), 60, 2, -1);
        expect_reply(none);
        m.send(f, 60, 2, 3);
        expect_reply(none);
        m.send('{8'h01, 8'h41}, 60, 2, -1);
        expect_reply(none);
        m.send(f, 60, 25, -1);
        expect_reply(none);
        check(16'(drops - d0), 16'd4);
        m.send(frame('{8'h00, 8'h41, 8'h70, 8'h00, 8'h00, 8'h01}, 1'b0), 60, 2, -1);
        expect_reply(none);
        check({req_bcast_r, req_reg_r[14:0]}, 16'hf000);
        check(req_value_r, 16'h0001);
        check({8'h00, req_fc_r}, 16'h0041);
        baud_sel = `MBS_BAUD_4800;
        m.send(f, 0, 2, -1);
        expect_reply(f);
        m.send(f, 40, 2, -1);
        expect_reply(none);
        baud_sel = `MBS_BAUD_19200;
        m.send(f, 60, 0, -1);
        expect_reply(f);
        baud_sel = 2'd3;
        m.send(f, 60, 0, -1);
        expect_reply(f);
        baud_sel = `MBS_BAUD_9600;
        nvm = 1'b1;
        m.send(f, 60, 2, -1);
        repeat (300) @(negedge sys_clk);
        check(16'(m.got.size()), 16'd0);
        nvm = 1'b0;
        expect_reply(f);
        tmo = 16'd30;
        repeat (400) @(negedge sys_clk);
        check({15'h0, comm_timeout_r}, 16'h1);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        check({11'h0, tx_valid_r, tx_en_r, req_valid_r, comm_timeout_r, frame_drop_r}, 16'h0);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({15'h0, comm_timeout_r}, 16'h0);
        repeat (400) @(negedge sys_clk);
        check({15'h0, comm_timeout_r}, 16'h1);
        tmo = 16'h0;
        repeat (3) @(negedge sys_clk);
        check({15'h0, comm_timeout_r}, 16'h0);
        complete_run();
    end
endmodule // mbs_rtu_frame_tb
